// ---- bench/e1_overhead_mode_control_test.sv ----
// Self-checking bench for the overhead and mode control bank.
// Assumes the far-end model drives the receive side.
`timescale 1ns/1ns
`default_nettype none
module e1_overhead_mode_control_test;
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [4:0] cpu_addr = 5'h00;
  logic       cpu_wr = 1'b0;
  logic       cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic       tx_frame_start = 1'b0;
  logic       basic_sync_ok = 1'b0;
  logic       mf_align_ok = 1'b0;
  logic       ybit_manual_value = 1'b0;
  logic [4:0] national_buffer_word = 5'h00;
  logic       ais_mode = 1'b0;
  logic       rx_bit_valid, rx_bit, rx_sig_mf_start, rx_crc_mf_start;
  logic [7:0] cpu_rdata, tx_fas_intl_word, non_alignment_word;
  logic [4:0] spare_bit_link_mask;
  logic       tx_ybit, tx_transparent, crc4_sync_en, crc_interwork_en;
  logic       crc_remainder_modify_en, rx_multiframe_marker, ais_detect, soft_reset_pulse;
  int         n_fail = 0;
  int         cmp_count = 0;
  // Short AIS window keeps the run brief
  eomc_overhead_ctrl #(.AIS_WINDOW(16)) i_dut (.*);
  eomc_far_end i_far (.*);
  always #50 core_clk = ~core_clk;
  // ****************
  // Bus and check tasks
  // ****************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata, e);
  endtask : rd
  task automatic frame();
    @(posedge core_clk);
    tx_frame_start <= 1'b1;
    @(posedge core_clk);
    tx_frame_start <= 1'b0;
    #1;
  endtask : frame
  function automatic logic [4:0] exp_mask(input logic [7:0] r10, r11);
    return r11[2] ? eomc_pkg::SPARE_FIRST : r10[4:0];
  endfunction : exp_mask
  function automatic logic [7:0] exp_non_alignment_word(input logic [7:0] r10, r11, r12,
                                          input logic [4:0] nb, input logic s);
    return {r12[7], 1'b1, (r11[4] ? r12[5] : !s),
            (r10[5] ? nb : r12[4:0]) & ~exp_mask(r10, r11)};
  endfunction : exp_non_alignment_word
  task automatic summarize();
    $display("cmp_count=%0d n_fail=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // ****************
  // Tests
  // ****************
  initial begin
    logic [7:0] r10, r11, r12, prev;
    void'($urandom(32'hDE859873));
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(eomc_pkg::ADDR_MF_LINK_SEL, eomc_pkg::RST_MF_LINK_SEL);
    rd(eomc_pkg::ADDR_MODE_SEL, eomc_pkg::RST_MODE_SEL);
    rd(eomc_pkg::ADDR_NFA_CTRL, eomc_pkg::RST_NFA_CTRL);
    wr(5'h13, 8'hFF);
    rd(5'h13, eomc_pkg::RDATA_UNMAPPED);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      r10 = 8'($urandom());
      r11 = 8'($urandom()) & 8'hDF;
      r12 = 8'($urandom()) & 8'hBF;
      // Corner: transparent with every select bit set
      if (i == 0) r10 = 8'hFF;
      if (i == 0) r11 = 8'hDF;
      prev = non_alignment_word;
      wr(eomc_pkg::ADDR_MF_LINK_SEL, r10);
      wr(eomc_pkg::ADDR_MODE_SEL, r11);
      wr(eomc_pkg::ADDR_NFA_CTRL, r12);
      national_buffer_word <= 5'($urandom());
      {basic_sync_ok, mf_align_ok, ybit_manual_value} <= 3'($urandom());
      repeat (2) @(posedge core_clk);
      #1 chk(non_alignment_word, prev);
      chk(8'({tx_transparent, crc4_sync_en, crc_interwork_en, crc_remainder_modify_en}),
          8'({r11[2], !r11[1], !r11[0], r11[6] & r11[2]}));
      rd(eomc_pkg::ADDR_NFA_CTRL, r12);
      frame();
      chk(non_alignment_word, exp_non_alignment_word(r10, r11, r12, national_buffer_word,
          basic_sync_ok));
      chk(8'(spare_bit_link_mask), 8'(exp_mask(r10, r11)));
      chk(tx_fas_intl_word, {r11[7], 7'h00});
      chk(8'(tx_ybit), 8'(r11[3] ? ybit_manual_value : !mf_align_ok));
    end
    $display("test overhead words done");
    for (int s = 0; s < 2; s++) begin
      wr(eomc_pkg::ADDR_MF_LINK_SEL, {1'b0, s[0], 6'h00});
      @(posedge core_clk iff rx_crc_mf_start);
      #1 chk(8'(rx_multiframe_marker), 8'(s[0]));
      @(posedge core_clk iff rx_sig_mf_start);
      #1 chk(8'(rx_multiframe_marker), 8'(!s[0]));
    end
    $display("test marker done");
    wr(eomc_pkg::ADDR_MODE_SEL, 8'h24);
    rd(eomc_pkg::ADDR_MODE_SEL, 8'h20);
    rd(eomc_pkg::ADDR_NFA_CTRL, eomc_pkg::RST_NFA_CTRL);
    rd(eomc_pkg::ADDR_MF_LINK_SEL, eomc_pkg::RST_MF_LINK_SEL);
    wr(eomc_pkg::ADDR_MODE_SEL, 8'h00);
    $display("test soft reset done");
    // One window is 16 strobes at one strobe per two cycles
    // Soft reset aligns the window, so the first clean window end is known
    for (int a = 0; a < 2; a++) begin
      wr(eomc_pkg::ADDR_MODE_SEL, 8'h24);
      wr(eomc_pkg::ADDR_MODE_SEL, 8'h00);
      wr(eomc_pkg::ADDR_MF_LINK_SEL, {a[0], 7'h00});
      ais_mode <= 1'b1;
      repeat (40) @(posedge core_clk);
      #1 chk(8'(ais_detect), a[0] ? 8'h00 : 8'h01);
      repeat (88) @(posedge core_clk);
      #1 chk(8'(ais_detect), 8'h01);
      @(posedge core_clk);
      ais_mode <= 1'b0;
      repeat (96) @(posedge core_clk);
      #1 chk(8'(ais_detect), 8'h00);
    end
    $display("test alarm detect done");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
endmodule : e1_overhead_mode_control_test
`default_nettype wire

// ---- bench/eomc_far_end.sv ----
// Far-end line model: receive bit strobes and multiframe pulses.
// Assumes one core clock; ais_mode asks for an all-ones stream.
`timescale 1ns/1ns
`default_nettype none
module eomc_far_end (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic ais_mode,
  output logic      rx_bit_valid,
  output logic      rx_bit,
  output logic      rx_sig_mf_start,
  output logic      rx_crc_mf_start
);
  logic [7:0] cnt_ff;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end
  // Off-strobe the data line keeps moving, so stale bits never look valid
  assign rx_bit_valid    = cnt_ff[0];
  assign rx_bit          = cnt_ff[0] ? (ais_mode | cnt_ff[1]) : cnt_ff[2];
  // Odd versus even counts: the two pulses can never coincide
  assign rx_sig_mf_start = cnt_ff[3:0] == 4'h0;
  assign rx_crc_mf_start = (cnt_ff % 8'h18) == 8'h05;
endmodule : eomc_far_end
`default_nettype wire

// ---- bench/eomc_overhead_ctrl_checker.sv ----
// Port-level checker for the overhead and mode control bank.
// Assumes the bind below; shadows only the mode register.
`timescale 1ns/1ns
`default_nettype none
module eomc_overhead_ctrl_checker (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic [4:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic [7:0] cpu_wdata,
  input wire logic       tx_frame_start,
  input wire logic       basic_sync_ok,
  input wire logic       mf_align_ok,
  input wire logic       ybit_manual_value,
  input wire logic       rx_sig_mf_start,
  input wire logic       rx_crc_mf_start,
  input wire logic [7:0] non_alignment_word,
  input wire logic [4:0] spare_bit_link_mask,
  input wire logic       tx_ybit,
  input wire logic       tx_transparent,
  input wire logic       crc4_sync_en,
  input wire logic       crc_interwork_en,
  input wire logic       rx_multiframe_marker,
  input wire logic       soft_reset_pulse
);
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    if (cpu_wr && cpu_addr == eomc_pkg::ADDR_MODE_SEL)
      nxt_mode = (cpu_wdata[5] && !mode_ff[5]) ? 8'h20 : cpu_wdata;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) mode_ff <= eomc_pkg::RST_MODE_SEL;
    else mode_ff <= nxt_mode;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_mode_wr;
    cpu_wr && cpu_addr == eomc_pkg::ADDR_MODE_SEL && !cpu_wdata[5];
  endsequence
  chk_mode_apply: assert property (s_mode_wr |-> ##2
    (tx_transparent == $past(cpu_wdata[2], 2) && crc4_sync_en == !$past(cpu_wdata[1], 2)
    && crc_interwork_en == !$past(cpu_wdata[0], 2))) else $error("mode outputs wrong");
  chk_rst_defaults: assert property ($rose(arst_n) |->
    crc4_sync_en && crc_interwork_en && !tx_transparent) else $error("reset modes wrong");
  chk_soft_once: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  chk_marker_src: assert property (rx_multiframe_marker |->
    $past(rx_sig_mf_start) || $past(rx_crc_mf_start)) else $error("stray marker");
  chk_oh_hold: assert property (!$past(tx_frame_start) && !$past(soft_reset_pulse)
    |-> $stable(non_alignment_word) && $stable(tx_ybit)) else $error("overhead mid-frame");
  chk_ybit_man: assert property (tx_frame_start && mode_ff[3] |=>
    tx_ybit == $past(ybit_manual_value)) else $error("manual Y wrong");
  chk_ybit_auto: assert property (tx_frame_start && !mode_ff[3] |=>
    tx_ybit != $past(mf_align_ok)) else $error("auto Y wrong");
  chk_abit_auto: assert property (tx_frame_start && !mode_ff[4] |=>
    non_alignment_word[5] != $past(basic_sync_ok)) else $error("auto A bit wrong");
  chk_transp_mask: assert property (tx_frame_start && mode_ff[2] |=>
    spare_bit_link_mask == eomc_pkg::SPARE_FIRST) else $error("transparent mask wrong");
  chk_link_zero: assert property (tx_frame_start |=> non_alignment_word[6] &&
    (non_alignment_word[4:0] & spare_bit_link_mask) == 5'h00) else $error("link bits set");
endmodule : eomc_overhead_ctrl_checker
bind eomc_overhead_ctrl eomc_overhead_ctrl_checker i_chk (.*);
`default_nettype wire

// ---- shared/eomc_pkg.sv ----
// Constants for the E1 overhead and mode control register bank.
// Assumes an 8-bit microprocessor port with a 5-bit address.
package eomc_pkg;
  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [4:0] ADDR_MF_LINK_SEL = 5'h10;
  localparam logic [4:0] ADDR_MODE_SEL    = 5'h11;
  localparam logic [4:0] ADDR_NFA_CTRL    = 5'h12;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] RST_MF_LINK_SEL = 8'h00;
  localparam logic [7:0] RST_MODE_SEL    = 8'h00;
  localparam logic [7:0] RST_NFA_CTRL    = 8'h9F;
  localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

  // ********************************************************
  // Field positions, multiframe and link select
  // ********************************************************
  localparam int BIT_AIS_SEL   = 7;
  localparam int BIT_MF_SEL    = 6;
  localparam int BIT_NAT_BUF   = 5;
  localparam int SPARE_MSB     = 4;
  localparam int SPARE_LSB     = 0;

  // ********************************************************
  // Field positions, mode selection
  // ********************************************************
  localparam int BIT_INTL_FAS  = 7;
  localparam int BIT_CRC_MOD   = 6;
  localparam int BIT_SOFT_RST  = 5;
  localparam int BIT_RAI_MAN   = 4;
  localparam int BIT_Y_MAN     = 3;
  localparam int BIT_TX_TRSP   = 2;
  localparam int BIT_CRC_SYNC  = 1;
  localparam int BIT_IWK_DIS   = 0;

  // ********************************************************
  // Field positions, non-frame-alignment control
  // ********************************************************
  localparam int BIT_INTL_NON_ALIGNMENT_WORD = 7;
  localparam int BIT_SPARE6    = 6;
  localparam int BIT_TX_ALARM  = 5;
  localparam int NAT_MSB       = 4;
  localparam int NAT_LSB       = 0;

  // ********************************************************
  // Link constants
  // ********************************************************
  localparam int          AIS_WINDOW_BITS = 512;
  localparam int          AIS_ZERO_LIMIT  = 3;
  localparam logic [4:0]  SPARE_FIRST     = 5'h10;
  localparam logic        NON_ALIGNMENT_WORD_BIT2       = 1'b1;
endpackage : eomc_pkg

// ---- src/eomc_ais_detect.sv ----
// AIS detector: counts zeros per 512-bit double-frame window.
// Assumes rx_bit is qualified by rx_bit_valid, one bit per strobe.
`timescale 1ns/1ns
`default_nettype none
module eomc_ais_detect #(
  parameter int WINDOW_BITS = eomc_pkg::AIS_WINDOW_BITS
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic soft_rst,
  input  wire logic rx_bit_valid,
  input  wire logic rx_bit,
  input  wire logic ais_criteria_select,
  output logic      ais_detect
);
  localparam int CW = $clog2(WINDOW_BITS);

  logic [CW-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic [1:0]    zero_cnt_ff, nxt_zero_cnt;
  logic          prev_ok_ff, nxt_prev_ok;
  logic          ais_ff, nxt_ais;

  always_comb begin
    logic win_end;
    logic win_ok;
    logic [1:0] zc;
    win_end      = 1'b0;
    win_ok       = 1'b0;
    zc           = zero_cnt_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_zero_cnt = zero_cnt_ff;
    nxt_prev_ok  = prev_ok_ff;
    nxt_ais      = ais_ff;
    if (soft_rst) begin
      nxt_bit_cnt  = '0;
      nxt_zero_cnt = 2'h0;
      nxt_prev_ok  = 1'b0;
      nxt_ais      = 1'b0;
    end else if (rx_bit_valid) begin
      // Saturate at the limit; only "fewer than three" matters
      if (!rx_bit && zc != 2'(eomc_pkg::AIS_ZERO_LIMIT)) begin
        zc = zc + 2'h1;
      end
      win_end = (bit_cnt_ff == CW'(WINDOW_BITS - 1));
      win_ok  = (zc < 2'(eomc_pkg::AIS_ZERO_LIMIT));
      if (win_end) begin
        nxt_bit_cnt  = '0;
        nxt_zero_cnt = 2'h0;
        nxt_prev_ok  = win_ok;
        nxt_ais      = ais_criteria_select ? (win_ok && prev_ok_ff) : win_ok;
      end else begin
        nxt_bit_cnt  = bit_cnt_ff + CW'(1);
        nxt_zero_cnt = zc;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff  <= '0;
      zero_cnt_ff <= 2'h0;
      prev_ok_ff  <= 1'b0;
      ais_ff      <= 1'b0;
    end else begin
      bit_cnt_ff  <= nxt_bit_cnt;
      zero_cnt_ff <= nxt_zero_cnt;
      prev_ok_ff  <= nxt_prev_ok;
      ais_ff      <= nxt_ais;
    end
  end

  assign ais_detect = ais_ff;
endmodule : eomc_ais_detect
`default_nettype wire

// ---- src/eomc_overhead_ctrl.sv ----
// E1 overhead and mode control registers with time slot zero overhead build.
// Assumes a synchronous microprocessor port: one-cycle write and read strobes,
// a transmit frame-start pulse and receive multiframe pulses from the framer.
// Contract
// - AIS criteria: one or two windows
// - Marker follows signalling or CRC-4 multiframe
// - NON_ALIGNMENT_WORD word source: buffer or register
// - Set spare-select bits route bits to link
// - Transparent mode forces first spare bit only
// - FAS international bit sent when CRC off
// - Remainder modify only in transparent mode
// - Soft reset bit rising restores defaults
// - A bit automatic from sync, or manual
// - Y bit automatic from alignment, or manual
// - Transparent mode imposes no framing
// - CRC-4 sync disable frees international bits
// - Interworking enabled while disable bit zero
// - NON_ALIGNMENT_WORD international bit sent when CRC off
// - Remote alarm bit is the A bit
// - National bits fill unassigned spare positions
`timescale 1ns/1ns
`default_nettype none
module eomc_overhead_ctrl #(
  parameter int AIS_WINDOW = eomc_pkg::AIS_WINDOW_BITS
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Microprocessor port
  input  wire logic [4:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  // Framer status and timing
  input  wire logic       tx_frame_start,
  input  wire logic       basic_sync_ok,
  input  wire logic       mf_align_ok,
  input  wire logic       ybit_manual_value,
  input  wire logic [4:0] national_buffer_word,
  input  wire logic       rx_sig_mf_start,
  input  wire logic       rx_crc_mf_start,
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_bit,
  // Transmit overhead
  output logic      [7:0] tx_fas_intl_word,
  output logic      [7:0] non_alignment_word,
  output logic      [4:0] spare_bit_link_mask,
  output logic            tx_ybit,
  output logic            tx_transparent,
  output logic            crc4_sync_en,
  output logic            crc_interwork_en,
  output logic            crc_remainder_modify_en,
  // Receive side and soft reset pulse
  output logic            rx_multiframe_marker,
  output logic            ais_detect,
  output logic            soft_reset_pulse
);
  // ********************************************************
  // Register file
  // ********************************************************
  logic [7:0] mf_link_ff, nxt_mf_link;
  logic [7:0] mode_ff,    nxt_mode;
  logic [7:0] nfa_ff,     nxt_nfa;
  logic       rst_bit_ff, nxt_rst_bit;
  logic       soft_rst_ff, nxt_soft_rst;
  logic [7:0] rdata_ff,   nxt_rdata;

  function automatic logic [7:0] reg_read(input logic [4:0] addr,
                                          input logic [7:0] r10,
                                          input logic [7:0] r11,
                                          input logic [7:0] r12);
    logic [7:0] val;
    val = eomc_pkg::RDATA_UNMAPPED;
    unique case (addr)
      eomc_pkg::ADDR_MF_LINK_SEL: val = r10;
      eomc_pkg::ADDR_MODE_SEL:    val = r11;
      eomc_pkg::ADDR_NFA_CTRL:    val = r12;
      default:                    val = eomc_pkg::RDATA_UNMAPPED;
    endcase
    return val;
  endfunction : reg_read

  always_comb begin
    logic rise;
    rise         = 1'b0;
    nxt_mf_link  = mf_link_ff;
    nxt_mode     = mode_ff;
    nxt_nfa      = nfa_ff;
    nxt_rst_bit  = rst_bit_ff;
    nxt_soft_rst = 1'b0;
    nxt_rdata    = rdata_ff;
    if (cpu_wr) begin
      unique case (cpu_addr)
        eomc_pkg::ADDR_MF_LINK_SEL: nxt_mf_link = cpu_wdata;
        eomc_pkg::ADDR_MODE_SEL: begin
          nxt_mode    = cpu_wdata;
          nxt_rst_bit = cpu_wdata[eomc_pkg::BIT_SOFT_RST];
          rise        = cpu_wdata[eomc_pkg::BIT_SOFT_RST] && !rst_bit_ff;
        end
        // Bit six is stored as written; keeping it zero is software's job
        eomc_pkg::ADDR_NFA_CTRL: nxt_nfa = cpu_wdata;
        default: ;
      endcase
    end
    // Only the zero-to-one edge resets; holding the bit high does nothing
    if (rise) begin
      nxt_mf_link  = eomc_pkg::RST_MF_LINK_SEL;
      nxt_mode     = eomc_pkg::RST_MODE_SEL;
      nxt_mode[eomc_pkg::BIT_SOFT_RST] = 1'b1;
      nxt_nfa      = eomc_pkg::RST_NFA_CTRL;
      nxt_soft_rst = 1'b1;
    end
    if (cpu_rd) begin
      nxt_rdata = reg_read(cpu_addr, mf_link_ff, mode_ff, nfa_ff);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mf_link_ff  <= eomc_pkg::RST_MF_LINK_SEL;
      mode_ff     <= eomc_pkg::RST_MODE_SEL;
      nfa_ff      <= eomc_pkg::RST_NFA_CTRL;
      rst_bit_ff  <= 1'b0;
      soft_rst_ff <= 1'b0;
      rdata_ff    <= eomc_pkg::RDATA_UNMAPPED;
    end else begin
      mf_link_ff  <= nxt_mf_link;
      mode_ff     <= nxt_mode;
      nfa_ff      <= nxt_nfa;
      rst_bit_ff  <= nxt_rst_bit;
      soft_rst_ff <= nxt_soft_rst;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign cpu_rdata        = rdata_ff;
  assign soft_reset_pulse = soft_rst_ff;

  // ********************************************************
  // Mode flags (static levels)
  // ********************************************************
  logic       trsp_ff,    nxt_trsp;
  logic       csync_ff,   nxt_csync;
  logic       iwk_ff,     nxt_iwk;
  logic       crcmod_ff,  nxt_crcmod;

  always_comb begin
    nxt_trsp   = mode_ff[eomc_pkg::BIT_TX_TRSP];
    nxt_csync  = !mode_ff[eomc_pkg::BIT_CRC_SYNC];
    nxt_iwk    = !mode_ff[eomc_pkg::BIT_IWK_DIS];
    // Remainder update has no meaning when the device frames itself
    nxt_crcmod = mode_ff[eomc_pkg::BIT_CRC_MOD] && mode_ff[eomc_pkg::BIT_TX_TRSP];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trsp_ff   <= 1'b0;
      csync_ff  <= 1'b1;
      iwk_ff    <= 1'b1;
      crcmod_ff <= 1'b0;
    end else begin
      trsp_ff   <= nxt_trsp;
      csync_ff  <= nxt_csync;
      iwk_ff    <= nxt_iwk;
      crcmod_ff <= nxt_crcmod;
    end
  end

  assign tx_transparent          = trsp_ff;
  assign crc4_sync_en            = csync_ff;
  assign crc_interwork_en        = iwk_ff;
  assign crc_remainder_modify_en = crcmod_ff;

  // ********************************************************
  // Time slot zero overhead, latched per frame
  // ********************************************************
  // Outputs change only on tx_frame_start so no frame sees a mix of old and
  // new settings; the cost is up to one frame of latency after a write.
  logic [7:0] fas_ff,   nxt_fas;
  logic [7:0] non_alignment_word_ff,  nxt_non_alignment_word;
  logic [4:0] mask_ff,  nxt_mask;
  logic       ybit_ff,  nxt_ybit;
  logic [4:0] spare_sel;
  logic [4:0] spare_nat;
  logic [4:0] spare_out;

  // Transparent mode ignores the select bits and hands only the first spare bit to the link
  assign spare_sel = mode_ff[eomc_pkg::BIT_TX_TRSP] ? eomc_pkg::SPARE_FIRST
                   : mf_link_ff[eomc_pkg::SPARE_MSB:eomc_pkg::SPARE_LSB];
  assign spare_nat = mf_link_ff[eomc_pkg::BIT_NAT_BUF] ? national_buffer_word
                   : nfa_ff[eomc_pkg::NAT_MSB:eomc_pkg::NAT_LSB];

  // Link positions are sent as zero here; the link controller fills them later
  for (genvar g = 0; g < 5; g++) begin : g_spare
    assign spare_out[g] = spare_sel[g] ? 1'b0 : spare_nat[g];
  end

  always_comb begin
    logic [4:0] sel;
    logic [4:0] sa;
    logic       abit;
    logic       intl;
    sel      = spare_sel;
    sa       = spare_out;
    abit     = 1'b0;
    intl     = 1'b1;
    nxt_fas  = fas_ff;
    nxt_non_alignment_word = non_alignment_word_ff;
    nxt_mask = mask_ff;
    nxt_ybit = ybit_ff;
    if (mode_ff[eomc_pkg::BIT_RAI_MAN]) begin
      abit = nfa_ff[eomc_pkg::BIT_TX_ALARM];
    end else begin
      abit = !basic_sync_ok;
    end
    intl = nfa_ff[eomc_pkg::BIT_INTL_NON_ALIGNMENT_WORD];
    if (tx_frame_start) begin
      // Bit one in MSB; the CRC engine overwrites it while sync is enabled
      nxt_fas  = {mode_ff[eomc_pkg::BIT_INTL_FAS], 7'h00};
      nxt_non_alignment_word = {intl, eomc_pkg::NON_ALIGNMENT_WORD_BIT2, abit, sa};
      nxt_mask = sel;
      nxt_ybit = mode_ff[eomc_pkg::BIT_Y_MAN] ? ybit_manual_value : !mf_align_ok;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fas_ff  <= 8'h80;
      non_alignment_word_ff <= 8'hFF;
      mask_ff <= 5'h00;
      ybit_ff <= 1'b1;
    end else begin
      fas_ff  <= nxt_fas;
      non_alignment_word_ff <= nxt_non_alignment_word;
      mask_ff <= nxt_mask;
      ybit_ff <= nxt_ybit;
    end
  end

  assign tx_fas_intl_word    = fas_ff;
  assign non_alignment_word  = non_alignment_word_ff;
  assign spare_bit_link_mask = mask_ff;
  assign tx_ybit             = ybit_ff;

  // ********************************************************
  // Receive multiframe marker
  // ********************************************************
  logic marker_ff, nxt_marker;

  always_comb begin
    nxt_marker = mf_link_ff[eomc_pkg::BIT_MF_SEL] ? rx_crc_mf_start : rx_sig_mf_start;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      marker_ff <= 1'b0;
    end else begin
      marker_ff <= nxt_marker;
    end
  end

  assign rx_multiframe_marker = marker_ff;

  // ********************************************************
  // AIS detection
  // ********************************************************
  eomc_ais_detect #(
    .WINDOW_BITS (AIS_WINDOW)
  ) u_ais (
    .core_clk            (core_clk),
    .arst_n              (arst_n),
    .soft_rst            (soft_rst_ff),
    .rx_bit_valid        (rx_bit_valid),
    .rx_bit              (rx_bit),
    .ais_criteria_select (mf_link_ff[eomc_pkg::BIT_AIS_SEL]),
    .ais_detect          (ais_detect)
  );
endmodule : eomc_overhead_ctrl
`default_nettype wire
